// [design/audio_adc_cfg_bank.v]
// Byte-wide configuration bank of the four-channel audio ADC: rate converter,
// rate ratio, activity detection, gain/compression and mixer enables.
// Assumes the control port and the ADC status inputs run on REF_CLK_I;
// only the serial data pin path comes from outside that domain.
`timescale 1ns/100ps
`default_nettype none
`include "audio_adc_cfg_defs.vh"

module audio_adc_cfg_bank (
  input  wire       REF_CLK_I,
  input  wire       RESET_N_I,
  // control port
  input  wire [7:0] REG_ADDR_I,
  input  wire [7:0] REG_WDATA_I,
  input  wire       REG_WR_I,
  input  wire       REG_RD_I,
  output reg  [7:0] REG_RDATA_O,
  output reg        REG_ACK_O,
  output reg        REG_ERR_O,
  // rate converter
  output wire       RATE_CONV_ENABLE_O,
  output wire       RATE_CONV_AUTODETECT_OFF_O,
  output wire       MAIN_RATE_MANUAL_O,
  output wire       MAIN_RATE_SOURCE_O,
  output reg        MAIN_RATE_FROM_SECONDARY_O,
  output reg  [2:0] RATIO_M_VALUE_O,
  output reg  [2:0] RATIO_N_VALUE_O,
  output reg        RATIO_M_AUTO_O,
  output reg        RATIO_N_AUTO_O,
  output reg        RATIO_CODE_ILLEGAL_O,
  // activity detection
  input  wire       RECORDING_I,
  input  wire       ACTIVITY_START_I,
  input  wire       ACTIVITY_END_I,
  input  wire       ACTIVITY_IRQ_I,
  input  wire       SERIAL_DATA_I,
  output wire [1:0] ACTIVITY_POWER_POLICY_O,
  output wire [1:0] ACTIVITY_CHANNEL_SELECT_O,
  output reg  [3:0] ACTIVITY_CHANNEL_ONEHOT_O,
  output reg        DETECT_ACTIVE_O,
  output reg        ADC_POWER_UP_REQ_O,
  output reg        ADC_POWER_DOWN_REQ_O,
  output reg        PIN_IRQ_MODE_O,
  output reg        SERIAL_DATA_OUT_O,
  // gain, compression, mixer
  output wire [3:0] GAIN_CTRL_ENABLE_O,
  output wire [3:0] COMPRESS_ENABLE_O,
  output wire       SIDE_CHAIN_MIXER_EN_O,
  output wire       CHANNEL_MIXER_EN_O
);

  // ========================================================================
  // address decode and write-merge helpers
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  function [7:0] merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmask;
    begin
      merge = (old_val & ~wmask) | (new_val & wmask);
    end
  endfunction

  // ========================================================================
  // storage
  reg  [7:0] rate_conv_r;
  reg  [7:0] rate_ratio_r;
  reg  [7:0] activity_r;
  reg  [7:0] gain_dyn_r;
  reg  [7:0] mixer_r;
  reg  [7:0] rate_conv_nxt;
  reg  [7:0] rate_ratio_nxt;
  reg  [7:0] activity_nxt;
  reg  [7:0] gain_dyn_nxt;
  reg  [7:0] mixer_nxt;

  wire       mapped;

  assign mapped = hit(REG_ADDR_I, `OFS_RATE_CONV)  |
                  hit(REG_ADDR_I, `OFS_RATE_RATIO) |
                  hit(REG_ADDR_I, `OFS_ACTIVITY)   |
                  hit(REG_ADDR_I, `OFS_GAIN_DYN)   |
                  hit(REG_ADDR_I, `OFS_MIXER);

  // read-only bits are masked away on every write
  always @* begin
    rate_conv_nxt  = rate_conv_r;
    rate_ratio_nxt = rate_ratio_r;
    activity_nxt   = activity_r;
    gain_dyn_nxt   = gain_dyn_r;
    mixer_nxt      = mixer_r;
    if (REG_WR_I) begin
      if (hit(REG_ADDR_I, `OFS_RATE_CONV)) begin
        rate_conv_nxt = merge(rate_conv_r, REG_WDATA_I, `WMASK_RATE_CONV);
      end
      if (hit(REG_ADDR_I, `OFS_RATE_RATIO)) begin
        rate_ratio_nxt = merge(rate_ratio_r, REG_WDATA_I, `WMASK_RATE_RATIO);
      end
      if (hit(REG_ADDR_I, `OFS_ACTIVITY)) begin
        activity_nxt = merge(activity_r, REG_WDATA_I, `WMASK_ACTIVITY);
      end
      if (hit(REG_ADDR_I, `OFS_GAIN_DYN)) begin
        gain_dyn_nxt = merge(gain_dyn_r, REG_WDATA_I, `WMASK_GAIN_DYN);
      end
      if (hit(REG_ADDR_I, `OFS_MIXER)) begin
        mixer_nxt = merge(mixer_r, REG_WDATA_I, `WMASK_MIXER);
      end
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      rate_conv_r  <= `RST_RATE_CONV;
      rate_ratio_r <= `RST_RATE_RATIO;
      activity_r   <= `RST_ACTIVITY;
      gain_dyn_r   <= `RST_GAIN_DYN;
      mixer_r      <= `RST_MIXER;
    end else begin
      rate_conv_r  <= rate_conv_nxt;
      rate_ratio_r <= rate_ratio_nxt;
      activity_r   <= activity_nxt;
      gain_dyn_r   <= gain_dyn_nxt;
      mixer_r      <= mixer_nxt;
    end
  end

  // ========================================================================
  // control port answer
  reg  [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = 8'h00;
    if (hit(REG_ADDR_I, `OFS_RATE_CONV)) begin
      rdata_nxt = rate_conv_r & `WMASK_RATE_CONV;
    end
    if (hit(REG_ADDR_I, `OFS_RATE_RATIO)) begin
      rdata_nxt = rate_ratio_r;
    end
    if (hit(REG_ADDR_I, `OFS_ACTIVITY)) begin
      rdata_nxt = activity_r & `WMASK_ACTIVITY;
    end
    if (hit(REG_ADDR_I, `OFS_GAIN_DYN)) begin
      rdata_nxt = gain_dyn_r;
    end
    if (hit(REG_ADDR_I, `OFS_MIXER)) begin
      rdata_nxt = mixer_r & `WMASK_MIXER;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 8'h00;
      REG_ACK_O   <= 1'b0;
      REG_ERR_O   <= 1'b0;
    end else begin
      REG_ACK_O <= REG_WR_I | REG_RD_I;
      REG_ERR_O <= (REG_WR_I | REG_RD_I) & ~mapped;
      if (REG_RD_I) begin
        REG_RDATA_O <= rdata_nxt;
      end
    end
  end

  // ========================================================================
  // rate converter and ratio
  wire [2:0] ratio_code [0:1];
  wire [2:0] ratio_val  [0:1];
  wire [1:0] ratio_auto;
  wire [1:0] ratio_legal;

  assign RATE_CONV_ENABLE_O         = rate_conv_r[`BIT_CONV_EN];
  assign RATE_CONV_AUTODETECT_OFF_O = rate_conv_r[`BIT_CONV_AUTO_OFF];
  assign MAIN_RATE_MANUAL_O         = rate_ratio_r[`BIT_MAIN_MANUAL];
  assign MAIN_RATE_SOURCE_O         = rate_ratio_r[`BIT_MAIN_SOURCE];

  assign ratio_code[0] = rate_ratio_r[`FLD_RATIO_M_HI:`FLD_RATIO_M_LO];
  assign ratio_code[1] = rate_ratio_r[`FLD_RATIO_N_HI:`FLD_RATIO_N_LO];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ratio
      ratio_code_decode u_dec (
        .code_i  (ratio_code[gi]),
        .value_o (ratio_val[gi]),
        .auto_o  (ratio_auto[gi]),
        .legal_o (ratio_legal[gi])
      );
    end
  endgenerate

  always @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      MAIN_RATE_FROM_SECONDARY_O <= 1'b0;
      RATIO_M_VALUE_O            <= 3'h0;
      RATIO_N_VALUE_O            <= 3'h0;
      RATIO_M_AUTO_O             <= 1'b1;
      RATIO_N_AUTO_O             <= 1'b1;
      RATIO_CODE_ILLEGAL_O       <= 1'b0;
    end else begin
      // secondary port only when manual selection is on
      MAIN_RATE_FROM_SECONDARY_O <= MAIN_RATE_MANUAL_O & MAIN_RATE_SOURCE_O;
      RATIO_M_VALUE_O            <= ratio_val[0];
      RATIO_N_VALUE_O            <= ratio_val[1];
      RATIO_M_AUTO_O             <= ratio_auto[0];
      RATIO_N_AUTO_O             <= ratio_auto[1];
      RATIO_CODE_ILLEGAL_O       <= ~(&ratio_legal);
    end
  end

  // ========================================================================
  // activity detection and power policy
  wire [1:0] policy;
  wire [1:0] chsel;
  wire       det_run;
  wire       pin_irq;
  reg        sd_meta_r;
  reg        sd_sync_r;

  assign policy                    = activity_r[`FLD_POLICY_HI:`FLD_POLICY_LO];
  assign chsel                     = activity_r[`FLD_CHSEL_HI:`FLD_CHSEL_LO];
  assign ACTIVITY_POWER_POLICY_O   = policy;
  assign ACTIVITY_CHANNEL_SELECT_O = chsel;

  // detection halts during recording unless allowed
  assign det_run = ~RECORDING_I | activity_r[`BIT_DET_RECORD];
  assign pin_irq = activity_r[`BIT_PIN_IRQ_EN] & ~RECORDING_I;

  always @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      sd_meta_r <= 1'b0;
      sd_sync_r <= 1'b0;
    end else begin
      sd_meta_r <= SERIAL_DATA_I;
      sd_sync_r <= sd_meta_r;
    end
  end

  always @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      ACTIVITY_CHANNEL_ONEHOT_O <= 4'h0;
      DETECT_ACTIVE_O           <= 1'b0;
      ADC_POWER_UP_REQ_O        <= 1'b0;
      ADC_POWER_DOWN_REQ_O      <= 1'b0;
      PIN_IRQ_MODE_O            <= 1'b0;
      SERIAL_DATA_OUT_O         <= 1'b0;
    end else begin
      ACTIVITY_CHANNEL_ONEHOT_O <= 4'h1 << chsel;
      DETECT_ACTIVE_O           <= det_run;
      // policy 3 is treated as user-controlled
      ADC_POWER_UP_REQ_O   <= det_run & ACTIVITY_START_I &
                              ((policy == `POLICY_DETECT) |
                               (policy == `POLICY_UP_ONLY));
      ADC_POWER_DOWN_REQ_O <= det_run & ACTIVITY_END_I &
                              (policy == `POLICY_DETECT);
      PIN_IRQ_MODE_O       <= pin_irq;
      SERIAL_DATA_OUT_O    <= pin_irq ? (ACTIVITY_IRQ_I & det_run) : sd_sync_r;
    end
  end

  // ========================================================================
  // gain, compression and mixer enables
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      // channel 1 sits in the highest bit of each nibble
      assign GAIN_CTRL_ENABLE_O[gi] = gain_dyn_r[`FLD_GAIN_HI - gi];
      assign COMPRESS_ENABLE_O[gi]  = gain_dyn_r[`FLD_COMP_HI - gi];
    end
  endgenerate

  assign SIDE_CHAIN_MIXER_EN_O = mixer_r[`BIT_SIDE_MIX];
  assign CHANNEL_MIXER_EN_O    = mixer_r[`BIT_CHAN_MIX];

endmodule // audio_adc_cfg_bank

`default_nettype wire

// [design/audio_adc_cfg_defs.vh]
// Offsets, field positions, reset values and write masks for the
// audio ADC configuration bank.
// Assumes an 8-bit register address and byte-wide register data.
//
// Summary of operation
// - Rate-converter control bit 7 turns the sample-rate converter on when set.
// - Rate-converter control bit 6 set turns rate auto-detection off.
// - Rate-converter bits 5..0 are read-only zero; software writes only zero.
// - Ratio bit 7 clear infers main rate; set takes it from source bit.
// - Under manual selection bit 6 picks primary (0) or secondary (1) port rate.
// - Ratio bits 5..3 give numerator m; 0 automatic; 5 and 7 unused.
// - Ratio bits 2..0 give denominator n, same coding as numerator.
// - Activity bits 7..6 set power policy: user, detection, mixed; 3 unused.
// - Activity bits 5..4 pick monitored channel 1..4; reset picks channel 3.
// - Activity bit 3 lets output pin carry interrupt while not recording.
// - Activity bit 1 keeps detection running during recording; the pin interrupt stays off while recording.
// - Register 0x24 bits 7..4 enable gain control on channels 1..4.
// - Register 0x24 bits 3..0 enable compression on channels 1..4.
// - Activity-detect register at 0x1E resets to 0x20.
// - Rate-converter control register resets to zero.
// - Ratio register resets to zero, selecting automatic inference.
// - Gain and compression enable register resets to zero.
// - Mixer register 0x2C bit 6 enables side-chain, bit 5 channel mixer.
`ifndef AUDIO_ADC_CFG_DEFS_VH
`define AUDIO_ADC_CFG_DEFS_VH

// ==========================================================================
// register offsets
`define OFS_RATE_CONV     8'h17
`define OFS_RATE_RATIO    8'h18
`define OFS_ACTIVITY      8'h1E
`define OFS_GAIN_DYN      8'h24
`define OFS_MIXER         8'h2C

// ==========================================================================
// reset values
`define RST_RATE_CONV     8'h00
`define RST_RATE_RATIO    8'h00
`define RST_ACTIVITY      8'h20
`define RST_GAIN_DYN      8'h00
`define RST_MIXER         8'h00

// ==========================================================================
// writable-bit masks
`define WMASK_RATE_CONV   8'hC0
`define WMASK_RATE_RATIO  8'hFF
`define WMASK_ACTIVITY    8'hFB
`define WMASK_GAIN_DYN    8'hFF
`define WMASK_MIXER       8'hF0

// ==========================================================================
// field positions
`define BIT_CONV_EN       7
`define BIT_CONV_AUTO_OFF 6
`define BIT_MAIN_MANUAL   7
`define BIT_MAIN_SOURCE   6
`define FLD_RATIO_M_HI    5
`define FLD_RATIO_M_LO    3
`define FLD_RATIO_N_HI    2
`define FLD_RATIO_N_LO    0
`define FLD_POLICY_HI     7
`define FLD_POLICY_LO     6
`define FLD_CHSEL_HI      5
`define FLD_CHSEL_LO      4
`define BIT_PIN_IRQ_EN    3
`define BIT_DET_RECORD    1
`define FLD_GAIN_HI       7
`define FLD_GAIN_LO       4
`define FLD_COMP_HI       3
`define FLD_COMP_LO       0
`define BIT_SIDE_MIX      6
`define BIT_CHAN_MIX      5

// ==========================================================================
// power policy codes
`define POLICY_USER       2'h0
`define POLICY_DETECT     2'h1
`define POLICY_UP_ONLY    2'h2

// ==========================================================================
// ratio codes
`define RATIO_AUTO        3'h0
`define RATIO_RSV_A       3'h5
`define RATIO_RSV_B       3'h7

`endif

// [design/ratio_code_decode.v]
// Decoder for one rate-ratio term code (numerator or denominator).
// Assumes a 3-bit code taken straight from the ratio register.
`timescale 1ns/100ps
`default_nettype none
`include "audio_adc_cfg_defs.vh"

module ratio_code_decode (
  input  wire [2:0] code_i,
  output wire [2:0] value_o,
  output wire       auto_o,
  output wire       legal_o
);

  // codes 5 and 7 carry no ratio value
  assign auto_o  = (code_i == `RATIO_AUTO);
  assign legal_o = (code_i != `RATIO_RSV_A) && (code_i != `RATIO_RSV_B);
  assign value_o = legal_o ? code_i : 3'h0;

endmodule // ratio_code_decode

`default_nettype wire

// [bench/audio_adc_cfg_bank_properties.sv]
// Port checker for the audio ADC configuration bank.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module audio_adc_cfg_bank_properties (
  input wire logic       REF_CLK_I,
  input wire logic       RESET_N_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic       REG_ACK_O,
  input wire logic       REG_ERR_O,
  input wire logic       RATE_CONV_ENABLE_O,
  input wire logic       RATE_CONV_AUTODETECT_OFF_O,
  input wire logic [2:0] RATIO_M_VALUE_O,
  input wire logic       RATIO_M_AUTO_O,
  input wire logic       RECORDING_I,
  input wire logic       ACTIVITY_START_I,
  input wire logic       ACTIVITY_END_I,
  input wire logic [1:0] ACTIVITY_POWER_POLICY_O,
  input wire logic [1:0] ACTIVITY_CHANNEL_SELECT_O,
  input wire logic [3:0] ACTIVITY_CHANNEL_ONEHOT_O,
  input wire logic       DETECT_ACTIVE_O,
  input wire logic       ADC_POWER_UP_REQ_O,
  input wire logic       ADC_POWER_DOWN_REQ_O,
  input wire logic [3:0] GAIN_CTRL_ENABLE_O,
  input wire logic [3:0] COMPRESS_ENABLE_O,
  input wire logic       SIDE_CHAIN_MIXER_EN_O,
  input wire logic       CHANNEL_MIXER_EN_O
);
  // ==========================================================================
  // request decode and expected field values
  wire       w17    = REG_WR_I && REG_ADDR_I == 8'h17;
  wire       w18    = REG_WR_I && REG_ADDR_I == 8'h18;
  wire       w24    = REG_WR_I && REG_ADDR_I == 8'h24;
  wire       w2c    = REG_WR_I && REG_ADDR_I == 8'h2C;
  wire       mapped = REG_ADDR_I inside {8'h17, 8'h18, 8'h1E, 8'h24, 8'h2C};
  wire [2:0] wm     = REG_WDATA_I[5:3];
  wire [2:0] m_exp  = (wm == 3'h5 || wm == 3'h7) ? 3'h0 : wm;
  wire [3:0] g_exp  = {REG_WDATA_I[4], REG_WDATA_I[5], REG_WDATA_I[6], REG_WDATA_I[7]};
  wire [3:0] c_exp  = {REG_WDATA_I[0], REG_WDATA_I[1], REG_WDATA_I[2], REG_WDATA_I[3]};
  wire       up_ok  = ACTIVITY_POWER_POLICY_O inside {2'h1, 2'h2};
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ==========================================================================
  // assertions
  a_ack_follows_req: assert property ((REG_WR_I || REG_RD_I) |=> REG_ACK_O)
    else $error("no ack after access");
  a_conv_bits_write: assert property (w17 |=>
    RATE_CONV_ENABLE_O == $past(REG_WDATA_I[7]) &&
    RATE_CONV_AUTODETECT_OFF_O == $past(REG_WDATA_I[6])) else $error("rate conv bits");
  a_conv_rsvd_zero: assert property (REG_RD_I && REG_ADDR_I == 8'h17
    |=> REG_RDATA_O[5:0] == 6'h00) else $error("reserved bits not zero");
  a_ratio_m_decode: assert property (w18 ##1 1'b1 |=> RATIO_M_VALUE_O == $past(m_exp, 2)
    && RATIO_M_AUTO_O == ($past(wm, 2) == 3'h0)) else $error("ratio m decode");
  a_chan_onehot: assert property ($past(RESET_N_I) |->
    ACTIVITY_CHANNEL_ONEHOT_O == 4'h1 << $past(ACTIVITY_CHANNEL_SELECT_O)) else $error("onehot");
  a_detect_idle: assert property (!RECORDING_I |=> DETECT_ACTIVE_O)
    else $error("detect inactive while idle");
  a_power_up_req: assert property ($past(RESET_N_I) && !$past(RECORDING_I) && !RECORDING_I
    && ACTIVITY_START_I && up_ok |=> ADC_POWER_UP_REQ_O) else $error("missing power up");
  a_power_down_only: assert property (ADC_POWER_DOWN_REQ_O |-> $past(ACTIVITY_END_I)
    && $past(ACTIVITY_POWER_POLICY_O) == 2'h1) else $error("stray power down");
  a_gain_comp_write: assert property (w24 |=> GAIN_CTRL_ENABLE_O == $past(g_exp)
    && COMPRESS_ENABLE_O == $past(c_exp)) else $error("gain or compress enables");
  a_mixer_write: assert property (w2c |=> SIDE_CHAIN_MIXER_EN_O == $past(REG_WDATA_I[6])
    && CHANNEL_MIXER_EN_O == $past(REG_WDATA_I[5])) else $error("mixer enables");
  a_unmapped_err: assert property (REG_RD_I && !mapped |=> REG_ERR_O
    && REG_RDATA_O == 8'h00) else $error("unmapped read");
endmodule // audio_adc_cfg_bank_properties

bind audio_adc_cfg_bank audio_adc_cfg_bank_properties u_props (
  .REF_CLK_I, .RESET_N_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
  .REG_ACK_O, .REG_ERR_O, .RATE_CONV_ENABLE_O, .RATE_CONV_AUTODETECT_OFF_O, .RATIO_M_VALUE_O,
  .RATIO_M_AUTO_O, .RECORDING_I, .ACTIVITY_START_I, .ACTIVITY_END_I, .ACTIVITY_POWER_POLICY_O,
  .ACTIVITY_CHANNEL_SELECT_O, .ACTIVITY_CHANNEL_ONEHOT_O, .DETECT_ACTIVE_O, .ADC_POWER_UP_REQ_O,
  .ADC_POWER_DOWN_REQ_O, .GAIN_CTRL_ENABLE_O, .COMPRESS_ENABLE_O, .SIDE_CHAIN_MIXER_EN_O,
  .CHANNEL_MIXER_EN_O
);
`default_nettype wire

// [bench/audio_adc_cfg_bank_test.sv]
// Self-checking bench for the audio ADC configuration bank.
// Assumes every access is acked one cycle after it is taken.
`timescale 1ns/100ps
`default_nettype none
module audio_adc_cfg_bank_test;
  // ==========================================================================
  // signals
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rec = 1'b0;
  logic       a_start = 1'b0, a_end = 1'b0, a_irq = 1'b0, sdi = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  wire  [7:0] rdata;
  wire  [2:0] m_val, n_val;
  wire  [1:0] policy, chsel;
  wire  [3:0] onehot, gain, comp;
  wire        ack, err, c_en, c_off, manual, source, from_sec, m_auto, n_auto, illegal;
  wire        det, up, down, pin_irq, sdo, side_mix, chan_mix;
  int         err_count, n_checks, i;
  logic [7:0] ofs [5] = '{8'h17, 8'h18, 8'h1E, 8'h24, 8'h2C};
  logic [7:0] rstv [5] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00};
  logic [7:0] msk [5] = '{8'hC0, 8'hFF, 8'hFB, 8'hFF, 8'hF0};

  audio_adc_cfg_bank DUT (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_ACK_O(ack), .REG_ERR_O(err),
    .RATE_CONV_ENABLE_O(c_en), .RATE_CONV_AUTODETECT_OFF_O(c_off),
    .MAIN_RATE_MANUAL_O(manual), .MAIN_RATE_SOURCE_O(source),
    .MAIN_RATE_FROM_SECONDARY_O(from_sec), .RATIO_M_VALUE_O(m_val), .RATIO_N_VALUE_O(n_val),
    .RATIO_M_AUTO_O(m_auto), .RATIO_N_AUTO_O(n_auto), .RATIO_CODE_ILLEGAL_O(illegal),
    .RECORDING_I(rec), .ACTIVITY_START_I(a_start), .ACTIVITY_END_I(a_end),
    .ACTIVITY_IRQ_I(a_irq), .SERIAL_DATA_I(sdi), .ACTIVITY_POWER_POLICY_O(policy),
    .ACTIVITY_CHANNEL_SELECT_O(chsel), .ACTIVITY_CHANNEL_ONEHOT_O(onehot),
    .DETECT_ACTIVE_O(det), .ADC_POWER_UP_REQ_O(up), .ADC_POWER_DOWN_REQ_O(down),
    .PIN_IRQ_MODE_O(pin_irq), .SERIAL_DATA_OUT_O(sdo), .GAIN_CTRL_ENABLE_O(gain),
    .COMPRESS_ENABLE_O(comp), .SIDE_CHAIN_MIXER_EN_O(side_mix), .CHANNEL_MIXER_EN_O(chan_mix)
  );

  // ==========================================================================
  // tasks
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // all strobes set once per falling edge, sampled just after the next rising edge
  task drv(input logic w, r, s, e, input logic [7:0] a, d);
    @(negedge clk);
    wr = w;
    rd = r;
    a_start = s;
    a_end = e;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
  endtask
  task idle(input int n);
    repeat (n) drv(0, 0, 0, 0, 8'h00, 8'h00);
  endtask
  task acc(input logic w, input logic [7:0] a, d, e);
    drv(w, !w, 0, 0, a, d);
    chk({err, ack}, {!(a inside {8'h17, 8'h18, 8'h1E, 8'h24, 8'h2C}), 1'b1});
    if (!w) chk(rdata, e);
  endtask
  task pulse(input logic s, e, eu, ed);
    drv(0, 0, s, e, 8'h00, 8'h00);
    chk({up, down}, {eu, ed});
  endtask
  function automatic logic [2:0] dec(input logic [2:0] c);
    return (c == 3'h5 || c == 3'h7) ? 3'h0 : c;
  endfunction
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog, tests
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (i = 0; i < 5; i++) acc(0, ofs[i], 8'h00, rstv[i]);
    chk({chsel, m_auto, n_auto}, 4'hB);
    $display("test reset values done");
    for (i = 0; i < 5; i++) begin
      acc(1, ofs[i], 8'hFF, 8'h00);
      acc(0, ofs[i], 8'h00, msk[i]);
      acc(1, ofs[i], 8'h00, 8'h00);
      acc(0, ofs[i], 8'h00, 8'h00);
    end
    acc(1, 8'h24, 8'hA5, 8'h00);
    chk({gain, comp}, 8'h5A);
    acc(1, 8'h2C, 8'h60, 8'h00);
    acc(1, 8'h17, 8'h80, 8'h00);
    chk({side_mix, chan_mix, c_en, c_off}, 4'hE);
    acc(1, 8'h17, 8'h40, 8'h00);
    chk({c_en, c_off}, 2'h1);
    acc(1, 8'h19, 8'h55, 8'h00);
    acc(0, 8'h19, 8'h00, 8'h00);
    $display("test write and read back done");
    for (i = 0; i < 8; i++) begin
      acc(1, 8'h18, {1'b1, i[0], i[2:0], ~i[2:0]}, 8'h00);
      idle(1);
      chk({m_val, n_val}, {dec(i[2:0]), dec(~i[2:0])});
      chk({m_auto, n_auto, illegal, manual, source, from_sec},
          {i == 0, i == 7, i inside {0, 2, 5, 7}, 1'b1, i[0], i[0]});
    end
    acc(1, 8'h18, 8'h40, 8'h00);
    idle(1);
    chk({manual, source, from_sec}, 3'h2);
    $display("test rate ratio done");
    for (i = 0; i < 4; i++) begin
      acc(1, 8'h1E, {i[1:0], i[1:0], 4'h0}, 8'h00);
      idle(1);
      chk({policy, onehot}, {i[1:0], 4'h1 << i});
      pulse(1, 0, i == 1 || i == 2, 0);
      pulse(0, 1, 0, i == 1);
    end
    acc(1, 8'h1E, 8'h48, 8'h00);
    // drop the write strobe here, or the next edge repeats the write
    @(negedge clk);
    wr = 1'b0;
    rec = 1'b1;
    idle(2);
    chk({det, pin_irq}, 2'h0);
    pulse(1, 0, 0, 0);
    acc(1, 8'h1E, 8'h4A, 8'h00);
    idle(1);
    chk(det, 1'b1);
    pulse(1, 0, 1, 0);
    // drop the start pulse here, or the next edge counts a second start
    @(negedge clk);
    a_start = 1'b0;
    sdi = 1'b1;
    idle(4);
    chk({pin_irq, sdo}, 2'h1);
    @(negedge clk);
    rec = 1'b0;
    a_irq = 1'b1;
    sdi = 1'b0;
    idle(4);
    chk({pin_irq, sdo}, 2'h3);
    @(negedge clk);
    a_irq = 1'b0;
    sdi = 1'b1;
    idle(4);
    chk(sdo, 1'b0);
    $display("test activity detect done");
    report_and_stop();
  end
endmodule // audio_adc_cfg_bank_test
`default_nettype wire
